// >>> adc_seq_ctrl.sv
// Purpose: Converter power-up, conversion sequencing and link register access
// Assumes: Host waits three CLK periods after CS_N falls before the first SCK edge
// Notes:   Link side runs on SCK; events cross by toggles, words are frozen per frame
//
// Operation
// - Reference powers on its enable bit
// - Reference enable independent of everything else
// - Converter enable starts it; ready after start-up
// - A start register write starts conversion when ready and idle
// - Sample, convert, store result, set done
// - Sweep bit converts all sixteen channels
// - Result read clears done, clock enabled
// - Status byte read-only, done at bit two
// - Status byte shifts out during address
// - Sampling lasts sixteen converter cycles
// - Thirteen convert, twelve calibration cycles
// - Result ten bits, low two bits zero
`timescale 1ns/1ns
module adc_seq_ctrl
  import adc_seq_pkg::*;
#(
  parameter int STARTUP = STARTUP_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       SCK,
  input  wire logic       CS_N,
  input  wire logic       SERIAL_IN_PIN,
  output logic            SERIAL_OUT,
  input  wire logic       REF_UP,
  input  wire logic [7:0] CONV_CODE,
  output logic            REF_EN,
  output logic            CONV_CLK_EN,
  output logic            CONV_EN,
  output logic            CONV_SAMPLE,
  output logic            CONV_CONVERT,
  output logic [3:0]      CONV_CHANNEL
);

  typedef enum logic [2:0] {S_IDLE, S_SAMPLE, S_CONVERT, S_CALIB, S_STORE} seq_t;

  // ---------------------------------------------------------------
  // Link side (SCK domain)
  // ---------------------------------------------------------------
  logic             frame_rst;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [22:0]      shift_r, shift_nxt;
  logic [6:0]       addr_r, addr_nxt;
  logic             wr_r, wr_nxt;
  logic             sel_mem_r, sel_mem_nxt;
  logic [15:0]      sreg_r, sreg_nxt;
  spi_frame_t       frame_r, frame_nxt;
  logic             wr_tgl_r, wr_tgl_nxt;
  logic             rd_tgl_r, rd_tgl_nxt;
  logic             miso_r;
  logic [15:0]      mem_rdata;
  logic [15:0]      rd_word;
  // Frozen CLK-domain copies, stable while a frame is open
  logic [7:0]       gsr_snap_r, gsr_snap_nxt;
  logic [15:0]      ctrl_snap_r, ctrl_snap_nxt;
  logic [15:0]      start_snap_r, start_snap_nxt;
  logic [15:0]      cstat_snap_r, cstat_snap_nxt;

  // A deselected link holds the frame logic in reset
  assign frame_rst = RST | CS_N;

  // Frame shifter, address decode and event toggles
  always_comb begin
    cnt_nxt     = cnt_r + CNT_W'(1);
    shift_nxt   = {shift_r[21:0], SERIAL_IN_PIN};
    addr_nxt    = addr_r;
    wr_nxt      = wr_r;
    sel_mem_nxt = sel_mem_r;
    sreg_nxt    = sreg_r;
    frame_nxt   = frame_r;
    wr_tgl_nxt  = wr_tgl_r;
    rd_tgl_nxt  = rd_tgl_r;
    if (cnt_r == CNT_W'(7)) begin
      addr_nxt    = shift_r[6:0];
      wr_nxt      = SERIAL_IN_PIN;
      sel_mem_nxt = is_result(shift_r[6:0]);
      unique case (shift_r[6:0])
        CTRL_ADDR:  sreg_nxt = ctrl_snap_r;
        START_ADDR: sreg_nxt = start_snap_r;
        CSTAT_ADDR: sreg_nxt = cstat_snap_r;
        default:    sreg_nxt = 16'h0000;
      endcase
      if (!SERIAL_IN_PIN && is_result(shift_r[6:0])) begin
        rd_tgl_nxt = ~rd_tgl_r;
      end
    end
    if (cnt_r == CNT_W'(FRAME_BITS - 1)) begin
      cnt_nxt = '0;
      if (wr_r) begin
        frame_nxt  = '{addr: addr_r, wr: 1'b1, data: {shift_r[14:0], SERIAL_IN_PIN}};
        wr_tgl_nxt = ~wr_tgl_r;
      end
    end
  end

  // Per-frame state, cleared whenever the link is deselected
  always_ff @(posedge SCK or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_r     <= '0;
      shift_r   <= '0;
      addr_r    <= '0;
      wr_r      <= 1'b0;
      sel_mem_r <= 1'b0;
      sreg_r    <= '0;
    end else begin
      cnt_r     <= cnt_nxt;
      shift_r   <= shift_nxt;
      addr_r    <= addr_nxt;
      wr_r      <= wr_nxt;
      sel_mem_r <= sel_mem_nxt;
      sreg_r    <= sreg_nxt;
    end
  end

  // Toggles and the write word must outlive the frame
  always_ff @(posedge SCK or posedge RST) begin
    if (RST) begin
      frame_r  <= '0;
      wr_tgl_r <= 1'b0;
      rd_tgl_r <= 1'b0;
    end else begin
      frame_r  <= frame_nxt;
      wr_tgl_r <= wr_tgl_nxt;
      rd_tgl_r <= rd_tgl_nxt;
    end
  end

  assign rd_word = sel_mem_r ? mem_rdata : sreg_r;

  // Output bit changes on the falling edge; the first bit is the reserved zero
  always_ff @(negedge SCK or posedge frame_rst) begin
    if (frame_rst) begin
      miso_r <= 1'b0;
    end else if (cnt_r < CNT_W'(STATUS_BITS)) begin
      miso_r <= gsr_snap_r[3'(3'd7 - cnt_r[2:0])];
    end else if (!wr_r) begin
      miso_r <= rd_word[4'(CNT_W'(FRAME_BITS - 1) - cnt_r)];
    end else begin
      miso_r <= 1'b0;
    end
  end

  assign SERIAL_OUT = miso_r;

  // ---------------------------------------------------------------
  // Crossing into CLK
  // ---------------------------------------------------------------
  logic [1:0] cs_sy_r, wr_sy_r, rd_sy_r, ref_sy_r;
  logic       wr_seen_r, rd_seen_r;
  logic [7:0] code_s1_r, code_s2_r;
  logic       cs_idle, wr_evt, rd_evt;

  // Two-stage synchronisers; only the second stage is read
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cs_sy_r   <= 2'h3;
      wr_sy_r   <= 2'h0;
      rd_sy_r   <= 2'h0;
      ref_sy_r  <= 2'h0;
      wr_seen_r <= 1'b0;
      rd_seen_r <= 1'b0;
      code_s1_r <= 8'h00;
      code_s2_r <= 8'h00;
    end else begin
      cs_sy_r   <= {cs_sy_r[0], CS_N};
      wr_sy_r   <= {wr_sy_r[0], wr_tgl_r};
      rd_sy_r   <= {rd_sy_r[0], rd_tgl_r};
      ref_sy_r  <= {ref_sy_r[0], REF_UP};
      wr_seen_r <= wr_sy_r[1];
      rd_seen_r <= rd_sy_r[1];
      code_s1_r <= CONV_CODE;
      code_s2_r <= code_s1_r;
    end
  end

  assign cs_idle = cs_sy_r[1];
  assign wr_evt  = wr_sy_r[1] ^ wr_seen_r;
  assign rd_evt  = rd_sy_r[1] ^ rd_seen_r;

  // ---------------------------------------------------------------
  // Control registers and conversion sequencer (CLK domain)
  // ---------------------------------------------------------------
  conv_ctrl_t ctrl_r, ctrl_nxt;
  logic [15:0] start_r, start_nxt;
  logic        done_r, done_nxt;
  logic        ready_r, ready_nxt;
  logic [5:0]  su_r, su_nxt;
  seq_t        st_r, st_nxt;
  logic [4:0]  cyc_r, cyc_nxt;
  logic [3:0]  ch_r, ch_nxt;
  logic        all_r, all_nxt;
  logic        mem_we, done_set, start_evt;
  logic [7:0]  gsr;

  assign start_evt = wr_evt && (frame_r.addr == START_ADDR);

  always_comb begin
    ctrl_nxt  = ctrl_r;
    start_nxt = start_r;
    su_nxt    = su_r;
    ready_nxt = ready_r;
    st_nxt    = st_r;
    cyc_nxt   = cyc_r + 5'd1;
    ch_nxt    = ch_r;
    all_nxt   = all_r;
    mem_we    = 1'b0;
    done_set  = 1'b0;
    if (wr_evt && frame_r.addr == CTRL_ADDR) begin
      ctrl_nxt = conv_ctrl_t'(frame_r.data[2:0]);
    end
    if (start_evt) begin
      start_nxt = frame_r.data;
    end
    // Start-up runs only on a running converter clock
    if (!ctrl_r.conv_en) begin
      su_nxt    = '0;
      ready_nxt = 1'b0;
    end else if (ctrl_r.clk_en && su_r != 6'(STARTUP)) begin
      su_nxt = su_r + 6'd1;
    end else if (su_r == 6'(STARTUP)) begin
      ready_nxt = 1'b1;
    end
    unique case (st_r)
      S_IDLE: begin
        cyc_nxt = '0;
        if (start_evt && ready_r) begin
          all_nxt = frame_r.data[START_ALL_BIT];
          ch_nxt  = frame_r.data[START_ALL_BIT] ? 4'h0
                    : frame_r.data[START_CH_LSB +: START_CH_W];
          st_nxt  = S_SAMPLE;
        end
      end
      S_SAMPLE: if (cyc_r == 5'(SAMPLE_CYC - 1)) begin
        cyc_nxt = '0;
        st_nxt  = S_CONVERT;
      end
      S_CONVERT: if (cyc_r == 5'(CONVERT_CYC - 1)) begin
        cyc_nxt = '0;
        st_nxt  = S_CALIB;
      end
      S_CALIB: if (cyc_r == 5'(CALIB_CYC - 1)) begin
        cyc_nxt = '0;
        st_nxt  = S_STORE;
      end
      S_STORE: begin
        cyc_nxt = '0;
        // Holding the write back keeps a frame's read word stable
        if (cs_idle) begin
          mem_we = 1'b1;
          if (all_r && ch_r != 4'(CHANNELS - 1)) begin
            ch_nxt = ch_r + 4'h1;
            st_nxt = S_SAMPLE;
          end else begin
            done_set = 1'b1;
            st_nxt   = S_IDLE;
          end
        end
      end
    endcase
    // A stopped converter clock freezes the phases; disabling aborts
    if (!ctrl_r.clk_en && st_r != S_IDLE) begin
      cyc_nxt = cyc_r;
      st_nxt  = st_r;
      mem_we  = 1'b0;
      done_set = 1'b0;
      ch_nxt  = ch_r;
    end
    if (!ctrl_r.conv_en) begin
      st_nxt   = S_IDLE;
      mem_we   = 1'b0;
      done_set = 1'b0;
    end
    // Set beats clear; clear needs the converter clock enabled
    done_nxt = done_set | (done_r & ~(rd_evt & ctrl_r.clk_en));
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_r  <= conv_ctrl_t'(CTRL_RESET);
      start_r <= START_RESET;
      done_r  <= 1'b0;
      ready_r <= 1'b0;
      su_r    <= '0;
      st_r    <= S_IDLE;
      cyc_r   <= '0;
      ch_r    <= '0;
      all_r   <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      start_r <= start_nxt;
      done_r  <= done_nxt;
      ready_r <= ready_nxt;
      su_r    <= su_nxt;
      st_r    <= st_nxt;
      cyc_r   <= cyc_nxt;
      ch_r    <= ch_nxt;
      all_r   <= all_nxt;
    end
  end

  // Status byte: only the done flag is live
  always_comb begin
    gsr               = GSR_RESET;
    gsr[GSR_DONE_BIT] = done_r;
  end

  // Snapshots refresh only while the link is idle
  always_comb begin
    gsr_snap_nxt   = gsr_snap_r;
    ctrl_snap_nxt  = ctrl_snap_r;
    start_snap_nxt = start_snap_r;
    cstat_snap_nxt = cstat_snap_r;
    if (cs_idle) begin
      gsr_snap_nxt   = gsr;
      ctrl_snap_nxt  = {13'h0000, ctrl_r};
      start_snap_nxt = start_r;
      cstat_snap_nxt = 16'h0000;
      cstat_snap_nxt[CSTAT_READY_BIT] = ready_r;
      cstat_snap_nxt[CSTAT_REFUP_BIT] = ref_sy_r[1];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      gsr_snap_r   <= GSR_RESET;
      ctrl_snap_r  <= '0;
      start_snap_r <= START_RESET;
      cstat_snap_r <= '0;
    end else begin
      gsr_snap_r   <= gsr_snap_nxt;
      ctrl_snap_r  <= ctrl_snap_nxt;
      start_snap_r <= start_snap_nxt;
      cstat_snap_r <= cstat_snap_nxt;
    end
  end

  // Result store: ten-bit field, the two low bits always zero
  result_mem #(.W(DATA_W), .DEPTH(CHANNELS), .AW(4)) u_res (
    .wclk  (CLK),
    .we    (mem_we),
    .waddr (ch_r),
    .wdata ({6'h00, code_s2_r, 2'h0}),
    .rclk  (SCK),
    .re    (cnt_r == CNT_W'(7)),
    .raddr (res_index(shift_r[6:0])),
    .rdata (mem_rdata)
  );

  // Analog-facing controls
  assign REF_EN       = ctrl_r.ref_en;
  assign CONV_CLK_EN  = ctrl_r.clk_en;
  assign CONV_EN      = ctrl_r.conv_en;
  assign CONV_SAMPLE  = (st_r == S_SAMPLE);
  assign CONV_CONVERT = (st_r == S_CONVERT);
  assign CONV_CHANNEL = ch_r;

endmodule : adc_seq_ctrl

// >>> adc_seq_pkg.sv
// Purpose: Shared constants and types for the converter sequence control block
// Assumes: 24-bit link frames: 7 address bits, 1 write bit, 16 data bits
// Notes:   Counts are converter clock cycles; the converter clock is CLK while enabled
package adc_seq_pkg;

  // ---------------------------------------------------------------
  // Link frame layout
  // ---------------------------------------------------------------
  localparam int ADDR_W      = 7;
  localparam int DATA_W      = 16;
  localparam int FRAME_BITS  = 24;
  localparam int STATUS_BITS = 8;
  localparam int CNT_W       = 5;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [6:0] CTRL_ADDR  = 7'h22;  // converter_control_register
  localparam logic [6:0] START_ADDR = 7'h23;  // conversion_start_register
  localparam logic [6:0] CSTAT_ADDR = 7'h24;  // converter_status_register
  localparam logic [6:0] RES_FIRST  = 7'h26;  // first of channel_result_registers
  localparam logic [6:0] RES_LAST   = 7'h35;  // last of channel_result_registers

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int START_CH_LSB    = 0;
  localparam int START_CH_W      = 4;
  localparam int START_ALL_BIT   = 4;
  localparam int CSTAT_READY_BIT = 0;
  localparam int CSTAT_REFUP_BIT = 1;
  localparam int GSR_DONE_BIT    = 2;
  localparam int RES_LSB         = 2;
  localparam int CODE_W          = 8;
  localparam logic [7:0]  GSR_RESET   = 8'h00;
  localparam logic [2:0]  CTRL_RESET  = 3'h0;
  localparam logic [15:0] START_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Conversion timing, in converter clock cycles
  // ---------------------------------------------------------------
  localparam int SAMPLE_CYC  = 16;
  localparam int CONVERT_CYC = 13;
  localparam int CALIB_CYC   = 12;
  localparam int CHANNELS    = 16;
  localparam int STARTUP_CYC = 32;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [6:0]  addr;
    logic        wr;
    logic [15:0] data;
  } spi_frame_t;

  typedef struct packed {
    logic conv_en;
    logic clk_en;
    logic ref_en;
  } conv_ctrl_t;

  // Result address decode, used for reads and the done-flag clear
  function automatic logic is_result(input logic [6:0] a);
    is_result = (a >= RES_FIRST) && (a <= RES_LAST);
  endfunction : is_result

  function automatic logic [3:0] res_index(input logic [6:0] a);
    logic [6:0] d;
    d = a - RES_FIRST;
    res_index = d[3:0];
  endfunction : res_index

endpackage : adc_seq_pkg

// >>> result_mem.sv
// Purpose: Result store, written on the system clock, read on the link clock
// Assumes: Writer never writes while a link frame is open
// Notes:   Read data comes out of a register on the link clock
`timescale 1ns/1ns
module result_mem #(
  parameter int W     = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic          wclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic          rclk,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);

  logic [W-1:0] mem [DEPTH];

  // Write port on the system clock
  always_ff @(posedge wclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port on the link clock
  always_ff @(posedge rclk) begin
    if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule : result_mem

// >>> adc_seq_ctrl_props.sv
// Purpose: Port assertions for the converter sequence control block
// Assumes: Converter clock stays enabled through a sampling or conversion phase
// Notes:   Link data bits are judged by the bench; these watch CLK-side timing
`timescale 1ns/1ns
module adc_seq_ctrl_props
  import adc_seq_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       CS_N,
  input wire logic       SERIAL_OUT,
  input wire logic       CONV_CLK_EN,
  input wire logic       CONV_EN,
  input wire logic       CONV_SAMPLE,
  input wire logic       CONV_CONVERT,
  input wire logic [3:0] CONV_CHANNEL
);
  // ---------------------------------------------------------------
  // Phase timing
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Whole phases, counted from their first cycle
  sequence sample16_s;
    CONV_SAMPLE [*8] ##1 CONV_SAMPLE [*8] ##1 !CONV_SAMPLE;
  endsequence
  sequence convert13_s;
    CONV_CONVERT [*8] ##1 CONV_CONVERT [*5] ##1 !CONV_CONVERT;
  endsequence

  AST_SAMPLE_LEN: assert property ($rose(CONV_SAMPLE) |-> sample16_s)
    else $error("sampling phase length wrong");
  AST_CONVERT_LEN: assert property ($rose(CONV_CONVERT) |-> convert13_s)
    else $error("conversion phase length wrong");
  AST_CONVERT_FOLLOWS: assert property ($rose(CONV_CONVERT) |-> $past(CONV_SAMPLE))
    else $error("conversion without sampling before it");
  // Calibration keeps the next sample away for twelve cycles
  AST_CALIB_GAP: assert property ($fell(CONV_CONVERT) |-> !CONV_SAMPLE throughout (##11 1'b1))
    else $error("sampling restarted inside calibration");
  AST_START_NEEDS_EN: assert property ($rose(CONV_SAMPLE) |-> CONV_EN && CONV_CLK_EN)
    else $error("sampling began without converter and clock enabled");
  AST_PHASE_EXCL: assert property (!(CONV_SAMPLE && CONV_CONVERT))
    else $error("sampling and conversion at once");
  AST_CHANNEL_HELD: assert property ((CONV_SAMPLE || CONV_CONVERT) && !$rose(CONV_SAMPLE)
    |-> $stable(CONV_CHANNEL))
    else $error("channel moved inside a conversion");
  // Deselected link must not leave a stale bit on the output
  AST_OUT_QUIET: assert property (CS_N && $past(CS_N) |-> !SERIAL_OUT)
    else $error("serial output driven while deselected");
endmodule : adc_seq_ctrl_props

bind adc_seq_ctrl adc_seq_ctrl_props props_u (
  .CLK(CLK), .RST(RST), .CS_N(CS_N), .SERIAL_OUT(SERIAL_OUT),
  .CONV_CLK_EN(CONV_CLK_EN), .CONV_EN(CONV_EN), .CONV_SAMPLE(CONV_SAMPLE),
  .CONV_CONVERT(CONV_CONVERT), .CONV_CHANNEL(CONV_CHANNEL)
);

// >>> spi_host_model.sv
// Purpose: Host link controller that runs whole 24-bit frames
// Assumes: Link clock of 64 ns, idle low, only inside frames
// Notes:   Status byte and read word are captured on rising link edges
`timescale 1ns/1ns
module spi_host_model (
  output logic      sck,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  // ---------------------------------------------------------------
  // Frame engine
  // ---------------------------------------------------------------
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // Address, direction, data out MSB first; gaps keep the device settled
  task automatic xfer(input logic [6:0] a, input logic w, input logic [15:0] d,
                      output logic [7:0] st, output logic [15:0] rd);
    logic [23:0] tx;
    logic [23:0] rx;
    tx = {a, w, d};
    rx = 24'h000000;
    cs_n = 1'b0;
    #150;
    for (int b = 23; b >= 0; b--) begin
      sdi = tx[b];
      #32 sck = 1'b1;
      rx[b] = sdo;
      #32 sck = 1'b0;
    end
    #32 cs_n = 1'b1;
    sdi = ~sdi;  // Released line shows no stale bit
    #150;
    st = rx[23:16];
    rd = rx[15:0];
  endtask : xfer
endmodule : spi_host_model

// >>> adc_seq_ctrl_tb.sv
// Purpose: Self-checking bench for converter sequencing over the link
// Assumes: Analog side modelled here: reference follows its enable
// Notes:   Converter code is {bias, channel} so each result is traceable
`timescale 1ns/1ns
module adc_seq_ctrl_tb;
  import adc_seq_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ref_up = 1'b0;
  logic [7:0]  code = 8'h00;
  logic [3:0]  bias = 4'hA;
  wire         sck, cs_n, sdi, sdo;
  logic        ref_en, clk_en, conv_en, smp, cnv;
  logic [3:0]  chan;
  logic [7:0]  st;
  logic [15:0] rd;
  int          fails = 0;
  int          total_checks = 0;
  int          cyc = 0;
  // Phase cycle counts, compared as differences across one conversion
  int          smp_cnt = 0;
  int          cnv_cnt = 0;
  int          smp_base;
  int          cnv_base;

  // ---------------------------------------------------------------
  // Design, host and analog stand-in
  // ---------------------------------------------------------------
  adc_seq_ctrl #(.STARTUP(4)) dut_u (
    .CLK(clk), .RST(rst), .SCK(sck), .CS_N(cs_n), .SERIAL_IN_PIN(sdi),
    .SERIAL_OUT(sdo), .REF_UP(ref_up), .CONV_CODE(code), .REF_EN(ref_en),
    .CONV_CLK_EN(clk_en), .CONV_EN(conv_en), .CONV_SAMPLE(smp),
    .CONV_CONVERT(cnv), .CONV_CHANNEL(chan)
  );
  spi_host_model host_u (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  always #20 clk = ~clk;

  // Analog follows at the falling edge; timeout guards a hang
  always @(negedge clk) begin
    ref_up <= ref_en;
    code <= {bias, chan};
    cyc <= cyc + 1;
    smp_cnt <= smp_cnt + int'(smp);
    cnv_cnt <= cnv_cnt + int'(cnv);
    if (cyc == 20000) begin
      fails++;
      $display("BAD %0t timeout", $time);
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rdr(input logic [6:0] a);
    host_u.xfer(a, 1'b0, 16'h0000, st, rd);
  endtask : rdr

  task automatic wrr(input logic [6:0] a, input logic [15:0] d);
    host_u.xfer(a, 1'b1, d, st, rd);
  endtask : wrr

  // Poll the status byte, bounded to 40 frames
  task automatic wait_done();
    int n;
    n = 0;
    st = 8'h00;
    while (st[GSR_DONE_BIT] !== 1'b1 && n < 40) begin
      rdr(CSTAT_ADDR);
      n++;
    end
  endtask : wait_done

  function automatic logic [15:0] res(input logic [3:0] b, input logic [3:0] c);
    res = {6'h00, b, c, 2'b00};
  endfunction : res

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk({13'h0, conv_en, clk_en, ref_en}, 16'h0000, "enables at reset");
    rdr(CSTAT_ADDR);
    chk({8'h00, st}, 16'h0000, "status byte reset");
    chk(rd, 16'h0000, "converter status reset");
    rdr(7'h7F);
    chk(rd, 16'h0000, "unmapped read");
    $display("test reset done");
    wrr(CTRL_ADDR, 16'h0001);
    repeat (12) @(negedge clk);
    chk({13'h0, conv_en, clk_en, ref_en}, 16'h0001, "reference alone");
    rdr(CSTAT_ADDR);
    chk(rd, 16'h0002, "reference up, not ready");
    wrr(CTRL_ADDR, 16'h0003);
    wrr(CTRL_ADDR, 16'h0007);
    repeat (20) @(negedge clk);
    rdr(CSTAT_ADDR);
    chk(rd, 16'h0003, "ready after start-up");
    $display("test power-up done");
    wrr(START_ADDR, 16'hFFE3);
    wait_done();
    chk({8'h00, st}, 16'h0004, "done alone in status byte");
    smp_base = smp_cnt;
    cnv_base = cnv_cnt;
    wrr(START_ADDR, 16'h0007);
    repeat (80) @(negedge clk);
    chk(16'(smp_cnt - smp_base), 16'(SAMPLE_CYC), "sampling cycles");
    chk(16'(cnv_cnt - cnv_base), 16'(CONVERT_CYC), "conversion cycles");
    rdr(CSTAT_ADDR);
    chk({8'h00, st}, 16'h0004, "done kept across second result");
    rdr(RES_FIRST + 7'd3);
    chk(rd, res(4'hA, 4'h3), "first single result");
    rdr(RES_FIRST + 7'd7);
    chk(rd, res(4'hA, 4'h7), "second single result");
    chk({8'h00, st}, 16'h0000, "done cleared by result read");
    $display("test single done");
    wrr(START_ADDR, 16'h0010);
    wait_done();
    for (int i = 0; i < CHANNELS; i++) begin
      rdr(RES_FIRST + 7'(i));
      chk(rd, res(4'hA, 4'(i)), "sweep result");
    end
    $display("test sweep done");
    bias = 4'h5;
    wrr(START_ADDR, 16'h0009);
    wait_done();
    wrr(CTRL_ADDR, 16'h0005);
    rdr(RES_FIRST + 7'd9);
    chk(rd, res(4'h5, 4'h9), "chosen channel result");
    rdr(RES_FIRST + 7'd8);
    chk({8'h00, st}, 16'h0004, "done kept with clock off");
    chk(rd, res(4'hA, 4'h8), "neighbour untouched");
    wrr(CTRL_ADDR, 16'h0007);
    rdr(RES_FIRST);
    rdr(CSTAT_ADDR);
    chk({8'h00, st}, 16'h0000, "done cleared with clock on");
    $display("test clock gate done");
    report_and_stop();
  end
endmodule : adc_seq_ctrl_tb
